/* File: hw/cit_core.sv */
`timescale 1ns/100ps
`default_nettype none
module cit_core (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Instruction issue
  input wire logic issue_valid,
  input wire cit_pkg::cit_issue_t issue_req,
  output logic issue_ready,
  // Execution progress
  output logic busy,
  output logic retire,
  output logic fetch_strobe,
  output cit_pkg::cit_cls_t exec_cls,
  output logic [1:0] exec_bytes,
  output logic [3:0] exec_cycles,
  output logic [3:0] cycles_left,
  output logic [15:0] branch_target
);

  typedef enum logic [0:0] {ST_IDLE, ST_EXEC} cit_state_t;

  logic rst_meta_n_ff;
  logic rst_sync_n_ff;
  cit_pkg::cit_dec_t dec;
  logic accept;
  logic [3:0] extra;
  logic [3:0] eff_cycles;

  cit_state_t state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [3:0] idx_ff, nxt_idx;
  cit_pkg::cit_cls_t cls_ff, nxt_cls;
  logic [1:0] bytes_ff, nxt_bytes;
  logic [3:0] cycles_ff, nxt_cycles;
  logic [15:0] target_ff, nxt_target;
  logic taken_ff, nxt_taken;

  // Reset release is synchronised; assertion is still immediate
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n_ff <= 1'b0;
      rst_sync_n_ff <= 1'b0;
    end else begin
      rst_meta_n_ff <= 1'b1;
      rst_sync_n_ff <= rst_meta_n_ff;
    end
  end

  cit_decode u_decode (
    .op(issue_req.op),
    .dec(dec)
  );

  // Only code reads through the data pointer stretch with fetch alignment and flash timing
  always_comb begin
    extra = {2'h0, issue_req.flash_read_timing_setting} + {3'h0, issue_req.odd_align}; // RQ20
    if (extra > (cit_pkg::CODE_DP_MAX - cit_pkg::CODE_DP_MIN)) begin
      extra = cit_pkg::CODE_DP_MAX - cit_pkg::CODE_DP_MIN; // RQ13
    end
    if (dec.variable) begin
      eff_cycles = dec.cycles + extra; // RQ13
    end else if (dec.cls == cit_pkg::CLS_COND && issue_req.taken) begin
      eff_cycles = dec.cycles + cit_pkg::CYC_ONE; // RQ3
    end else begin
      eff_cycles = dec.cycles; // RQ2
    end
  end

  // A new instruction may enter in the last clock of the current one
  assign issue_ready = (state_ff == ST_IDLE) || (cnt_ff == cit_pkg::CYC_ONE);
  assign accept = issue_valid && issue_ready;
  assign retire = (state_ff == ST_EXEC) && (cnt_ff == cit_pkg::CYC_ONE);
  assign busy = (state_ff == ST_EXEC);
  assign fetch_strobe = busy && (idx_ff < {2'h0, bytes_ff});

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_idx = idx_ff;
    nxt_cls = cls_ff;
    nxt_bytes = bytes_ff;
    nxt_cycles = cycles_ff;
    nxt_target = target_ff;
    nxt_taken = taken_ff;
    case (state_ff)
      ST_IDLE: begin
      end
      ST_EXEC: begin
        nxt_cnt = cnt_ff - cit_pkg::CYC_ONE; // RQ1
        nxt_idx = idx_ff + cit_pkg::CYC_ONE; // RQ1
        if (cnt_ff == cit_pkg::CYC_ONE) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (accept) begin
      nxt_state = ST_EXEC;
      nxt_cnt = eff_cycles;
      nxt_idx = '0;
      nxt_cls = dec.cls;
      nxt_bytes = dec.bytes;
      nxt_cycles = eff_cycles;
      nxt_taken = issue_req.taken;
      nxt_target = issue_req.next_pc + {{8{issue_req.rel_off[7]}}, issue_req.rel_off}; // RQ21
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      state_ff <= ST_IDLE;
      cnt_ff <= '0;
      idx_ff <= '0;
      cls_ff <= cit_pkg::CLS_NOP;
      bytes_ff <= '0;
      cycles_ff <= '0;
      target_ff <= '0;
      taken_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      idx_ff <= nxt_idx;
      cls_ff <= nxt_cls;
      bytes_ff <= nxt_bytes;
      cycles_ff <= nxt_cycles;
      target_ff <= nxt_target;
      taken_ff <= nxt_taken;
    end
  end

  assign exec_cls = cls_ff;
  assign exec_bytes = bytes_ff;
  assign exec_cycles = cycles_ff;
  assign cycles_left = cnt_ff;
  assign branch_target = target_ff;

  property p_count_down;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    (busy && !retire) |=> busy && (cnt_ff == $past(cnt_ff) - cit_pkg::CYC_ONE);
  endproperty
  a_count_down: assert property (p_count_down) else $error("cycle count did not step by one"); // RQ1

  property p_bytes_eq_cycles;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    (accept && !dec.variable && dec.cls != cit_pkg::CLS_COND && dec.cls == cit_pkg::CLS_MOV_DIR_DIR)
      |=> (cycles_ff == {2'h0, bytes_ff}) ##2 retire;
  endproperty
  a_bytes_eq_cycles: assert property (p_bytes_eq_cycles) else $error("clocks differ from bytes"); // RQ2

  property p_branch;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    (accept && dec.cls == cit_pkg::CLS_COND)
      |=> (cycles_ff == {2'h0, bytes_ff} + {3'h0, taken_ff});
  endproperty
  a_branch: assert property (p_branch) else $error("branch timing wrong"); // RQ3

  property p_alu_bank;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    (accept && dec.cls == cit_pkg::CLS_ALU_BANK) |=> retire && bytes_ff == cit_pkg::B1;
  endproperty
  a_alu_bank: assert property (p_alu_bank) else $error("register operation not single clock"); // RQ4

  property p_alu_dir;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    (accept && dec.cls == cit_pkg::CLS_ALU_DIR) |=> !retire && bytes_ff == cit_pkg::B2 ##1 retire;
  endproperty
  a_alu_dir: assert property (p_alu_dir) else $error("direct operation timing wrong"); // RQ5

  property p_alu_ind;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    (accept && dec.cls == cit_pkg::CLS_ALU_IND) |=> bytes_ff == cit_pkg::B1 && cycles_ff == cit_pkg::CLK2;
  endproperty
  a_alu_ind: assert property (p_alu_ind) else $error("indirect operation timing wrong"); // RQ6

  property p_log_imm;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    (accept && dec.cls == cit_pkg::CLS_LOG_DIR_IMM) |=> (busy && !retire) [*2] ##1 retire;
  endproperty
  a_log_imm: assert property (p_log_imm) else $error("immediate into direct timing wrong"); // RQ7

  property p_log_dir_a;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    (accept && dec.cls == cit_pkg::CLS_LOG_DIR_A) |=> bytes_ff == cit_pkg::B2 && cycles_ff == cit_pkg::CLK2;
  endproperty
  a_log_dir_a: assert property (p_log_dir_a) else $error("write-back logic timing wrong"); // RQ8

  property p_mov_dp;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    (accept && issue_req.op == cit_pkg::OP_MOV_DP) |=> cycles_ff == cit_pkg::CLK3 && bytes_ff == cit_pkg::B3;
  endproperty
  a_mov_dp: assert property (p_mov_dp) else $error("data pointer load timing wrong"); // RQ9

  property p_rot;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    (accept && dec.cls == cit_pkg::CLS_ROT) |=> retire;
  endproperty
  a_rot: assert property (p_rot) else $error("rotate not single clock"); // RQ10

  property p_ind_write;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    (accept && dec.cls == cit_pkg::CLS_MOV_IND_W) |=> cycles_ff == cit_pkg::CLK2;
  endproperty
  a_ind_write: assert property (p_ind_write) else $error("indirect write timing wrong"); // RQ11

  property p_code_dp;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    (accept && dec.cls == cit_pkg::CLS_CODE_DP)
      |=> cycles_ff >= cit_pkg::CODE_DP_MIN && cycles_ff <= cit_pkg::CODE_DP_MAX
          && cycles_ff == cit_pkg::CODE_DP_MIN + $past(extra); // RQ20
  endproperty
  a_code_dp: assert property (p_code_dp) else $error("code read range wrong"); // RQ13

  property p_three_clock;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    (accept && (dec.cls == cit_pkg::CLS_CODE_PC || dec.cls == cit_pkg::CLS_XD_DP ||
      dec.cls == cit_pkg::CLS_XD_RI)) |=> bytes_ff == cit_pkg::B1 ##2 retire;
  endproperty
  a_three_clock: assert property (p_three_clock) else $error("three clock move wrong"); // RQ14 RQ15 RQ16

  property p_two_byte_two_clock;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    (accept && (dec.cls == cit_pkg::CLS_STACK || dec.cls == cit_pkg::CLS_XCH_DIR))
      |=> bytes_ff == cit_pkg::B2 && !retire ##1 retire;
  endproperty
  a_two_byte_two_clock: assert property (p_two_byte_two_clock) else $error("stack or exchange wrong"); // RQ17 RQ18

  property p_nib_xch;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    (accept && dec.cls == cit_pkg::CLS_NIB_XCH) |=> bytes_ff == cit_pkg::B1 && cycles_ff == cit_pkg::CLK2;
  endproperty
  a_nib_xch: assert property (p_nib_xch) else $error("nibble exchange timing wrong"); // RQ19

  property p_target;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    accept |=> branch_target == $past(issue_req.next_pc) + {{8{$past(issue_req.rel_off[7])}},
      $past(issue_req.rel_off)};
  endproperty
  a_target: assert property (p_target) else $error("relative target wrong"); // RQ21

  property p_unused_op;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    (accept && issue_req.op == cit_pkg::OP_RESV) |=> exec_cls == cit_pkg::CLS_NOP && retire;
  endproperty
  a_unused_op: assert property (p_unused_op) else $error("unused opcode not a no-operation"); // RQ22

  // A refused request must leave the running instruction untouched
  property p_refused;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    (issue_valid && !issue_ready) |=> exec_cycles == $past(exec_cycles) && exec_bytes == $past(exec_bytes);
  endproperty
  a_refused: assert property (p_refused) else $error("refused request changed state"); // RQ1

  property p_first_clock;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    accept |=> busy && fetch_strobe && cycles_left == exec_cycles;
  endproperty
  a_first_clock: assert property (p_first_clock) else $error("first clock of instruction wrong"); // RQ1

  property p_end_idle;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    (retire && !accept) |=> !busy && !retire;
  endproperty
  a_end_idle: assert property (p_end_idle) else $error("still busy after retire"); // RQ1

  property p_fetch_all;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    (busy && exec_cycles == {2'h0, exec_bytes}) |-> fetch_strobe;
  endproperty
  a_fetch_all: assert property (p_fetch_all) else $error("fetch missing in byte-paced instruction"); // RQ2

  property p_fetch_stop;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    (retire && exec_cycles > {2'h0, exec_bytes}) |-> !fetch_strobe;
  endproperty
  a_fetch_stop: assert property (p_fetch_stop) else $error("fetch in a stretched last clock"); // RQ2

  property p_not_taken;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    (accept && dec.cls == cit_pkg::CLS_COND && dec.bytes == cit_pkg::B2 && !issue_req.taken)
      |=> !retire ##1 retire;
  endproperty
  a_not_taken: assert property (p_not_taken) else $error("branch not taken timing wrong"); // RQ3

  property p_taken;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    (accept && dec.cls == cit_pkg::CLS_COND && dec.bytes == cit_pkg::B2 && issue_req.taken)
      |=> (busy && !retire) [*2] ##1 retire;
  endproperty
  a_taken: assert property (p_taken) else $error("branch taken timing wrong"); // RQ3

  property p_code_dp_range;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    (busy && exec_cls == cit_pkg::CLS_CODE_DP)
      |-> exec_cycles >= cit_pkg::CODE_DP_MIN && exec_cycles <= cit_pkg::CODE_DP_MAX;
  endproperty
  a_code_dp_range: assert property (p_code_dp_range) else $error("code read count out of range"); // RQ13

  property p_rot_size;
    @(posedge mclk) disable iff (!rst_sync_n_ff)
    (accept && dec.cls == cit_pkg::CLS_ROT) |=> bytes_ff == cit_pkg::B1 && cycles_ff == cit_pkg::CLK1;
  endproperty
  a_rot_size: assert property (p_rot_size) else $error("rotate size wrong"); // RQ10

endmodule
`default_nettype wire

/* File: hw/cit_decode.sv */
`timescale 1ns/100ps
`default_nettype none
module cit_decode (
  // Opcode in
  input wire logic [7:0] op,
  // Timing class out
  output cit_pkg::cit_dec_t dec
);

  logic [3:0] row;
  logic [3:0] col;
  logic is_bank;
  logic is_ind;
  logic is_alu_row;
  logic is_log_row;

  assign row = op[7:4];
  assign col = op[3:0];
  assign is_bank = op[3];
  assign is_ind = (op[3:1] == cit_pkg::COL_IND);
  assign is_log_row = (row == cit_pkg::ROW_ORL) || (row == cit_pkg::ROW_ANL) || (row == cit_pkg::ROW_XRL);
  assign is_alu_row = is_log_row || (row == cit_pkg::ROW_ADD) || (row == cit_pkg::ROW_ADDC) ||
                      (row == cit_pkg::ROW_SUBB);

  function automatic cit_pkg::cit_dec_t mk(input cit_pkg::cit_cls_t c, input logic [1:0] b,
                                           input logic [3:0] n);
    mk = '{cls: c, bytes: b, cycles: n, variable: 1'b0};
  endfunction

  always_comb begin
    dec = mk(cit_pkg::CLS_OTHER, cit_pkg::B1, cit_pkg::CLK1);
    // Column patterns first; whole opcodes below override them
    if (is_alu_row && is_bank) begin
      dec = mk(cit_pkg::CLS_ALU_BANK, cit_pkg::B1, cit_pkg::CLK1); // RQ4
    end else if (is_alu_row && is_ind) begin
      dec = mk(cit_pkg::CLS_ALU_IND, cit_pkg::B1, cit_pkg::CLK2); // RQ6
    end else if (is_alu_row && (col == cit_pkg::COL_DIR || col == cit_pkg::COL_A_IMM)) begin
      dec = mk(cit_pkg::CLS_ALU_DIR, cit_pkg::B2, cit_pkg::CLK2); // RQ5
    end else if (is_log_row && col == cit_pkg::COL_DIR_A) begin
      dec = mk(cit_pkg::CLS_LOG_DIR_A, cit_pkg::B2, cit_pkg::CLK2); // RQ8
    end else if (is_log_row && col == cit_pkg::COL_DIR_IMM) begin
      dec = mk(cit_pkg::CLS_LOG_DIR_IMM, cit_pkg::B3, cit_pkg::CLK3); // RQ7
    end else begin
      case (row)
        cit_pkg::ROW_INC, cit_pkg::ROW_DEC: begin
          if (is_bank || col == cit_pkg::COL_A_IMM) dec = mk(cit_pkg::CLS_ACC, cit_pkg::B1, cit_pkg::CLK1);
          else if (is_ind) dec = mk(cit_pkg::CLS_ALU_IND, cit_pkg::B1, cit_pkg::CLK2);
          else if (col == cit_pkg::COL_DIR) dec = mk(cit_pkg::CLS_ALU_DIR, cit_pkg::B2, cit_pkg::CLK2);
        end
        cit_pkg::ROW_MOV_IMM: begin
          if (is_ind) dec = mk(cit_pkg::CLS_MOV_IND_W, cit_pkg::B2, cit_pkg::CLK2); // RQ11
          else if (is_bank || col == cit_pkg::COL_A_IMM) dec = mk(cit_pkg::CLS_MOV, cit_pkg::B2, cit_pkg::CLK2);
          else if (col == cit_pkg::COL_DIR) dec = mk(cit_pkg::CLS_MOV, cit_pkg::B3, cit_pkg::CLK3);
        end
        cit_pkg::ROW_MOV_TO_DIR, cit_pkg::ROW_MOV_FROM_DIR: begin
          if (is_bank || is_ind) dec = mk(is_ind && row == cit_pkg::ROW_MOV_FROM_DIR ?
            cit_pkg::CLS_MOV_IND_W : cit_pkg::CLS_MOV, cit_pkg::B2, cit_pkg::CLK2); // RQ11
        end
        cit_pkg::ROW_CJNE: begin
          if (col >= cit_pkg::CJNE_FIRST) dec = mk(cit_pkg::CLS_COND, cit_pkg::B3, cit_pkg::CLK3); // RQ3
        end
        cit_pkg::ROW_XCH: begin
          if (is_bank) dec = mk(cit_pkg::CLS_XCH, cit_pkg::B1, cit_pkg::CLK1);
          else if (is_ind) dec = mk(cit_pkg::CLS_XCH, cit_pkg::B1, cit_pkg::CLK2);
        end
        cit_pkg::ROW_DJNZ: begin
          if (is_bank) dec = mk(cit_pkg::CLS_COND, cit_pkg::B2, cit_pkg::CLK2); // RQ3
          else if (is_ind) dec = mk(cit_pkg::CLS_NIB_XCH, cit_pkg::B1, cit_pkg::CLK2); // RQ19
        end
        cit_pkg::ROW_MOV_TO_A, cit_pkg::ROW_MOV_FROM_A: begin
          if (is_bank) dec = mk(cit_pkg::CLS_MOV, cit_pkg::B1, cit_pkg::CLK1);
          else if (is_ind) dec = mk(row == cit_pkg::ROW_MOV_FROM_A ? cit_pkg::CLS_MOV_IND_W :
            cit_pkg::CLS_MOV, cit_pkg::B1, cit_pkg::CLK2); // RQ11
          else if (col == cit_pkg::COL_DIR) dec = mk(cit_pkg::CLS_MOV, cit_pkg::B2, cit_pkg::CLK2);
          else if (op[3:1] == cit_pkg::COL_XIND) dec = mk(cit_pkg::CLS_XD_RI, cit_pkg::B1, cit_pkg::CLK3); // RQ16
        end
        default: begin
        end
      endcase
    end
    case (op)
      cit_pkg::OP_NOP, cit_pkg::OP_RESV: dec = mk(cit_pkg::CLS_NOP, cit_pkg::B1, cit_pkg::CLK1); // RQ22
      cit_pkg::OP_INC_DP, cit_pkg::OP_DA, cit_pkg::OP_CLR_A, cit_pkg::OP_CLR_C:
        dec = mk(cit_pkg::CLS_ACC, cit_pkg::B1, cit_pkg::CLK1);
      cit_pkg::OP_CPL_A: dec = mk(cit_pkg::CLS_ACC, cit_pkg::B1, cit_pkg::CLK2);
      cit_pkg::OP_MUL: dec = mk(cit_pkg::CLS_ACC, cit_pkg::B1, cit_pkg::CLK4);
      cit_pkg::OP_DIV: dec = mk(cit_pkg::CLS_ACC, cit_pkg::B1, cit_pkg::CLK8);
      cit_pkg::OP_RR, cit_pkg::OP_RRC, cit_pkg::OP_RL, cit_pkg::OP_RLC, cit_pkg::OP_SWAP:
        dec = mk(cit_pkg::CLS_ROT, cit_pkg::B1, cit_pkg::CLK1); // RQ10
      cit_pkg::OP_MOV_DIR_DIR: dec = mk(cit_pkg::CLS_MOV_DIR_DIR, cit_pkg::B3, cit_pkg::CLK3); // RQ12
      cit_pkg::OP_MOV_DP: dec = mk(cit_pkg::CLS_MOV_DP, cit_pkg::B3, cit_pkg::CLK3); // RQ9
      cit_pkg::OP_CODE_DP: begin
        dec = mk(cit_pkg::CLS_CODE_DP, cit_pkg::B1, cit_pkg::CODE_DP_MIN); // RQ13
        dec.variable = 1'b1; // RQ20
      end
      cit_pkg::OP_CODE_PC: dec = mk(cit_pkg::CLS_CODE_PC, cit_pkg::B1, cit_pkg::CLK3); // RQ14
      cit_pkg::OP_XD_RD, cit_pkg::OP_XD_WR: dec = mk(cit_pkg::CLS_XD_DP, cit_pkg::B1, cit_pkg::CLK3); // RQ15
      cit_pkg::OP_PUSH, cit_pkg::OP_POP: dec = mk(cit_pkg::CLS_STACK, cit_pkg::B2, cit_pkg::CLK2); // RQ17
      cit_pkg::OP_XCH_DIR: dec = mk(cit_pkg::CLS_XCH_DIR, cit_pkg::B2, cit_pkg::CLK2); // RQ18
      cit_pkg::OP_CLR_BIT: dec = mk(cit_pkg::CLS_OTHER, cit_pkg::B2, cit_pkg::CLK2);
      cit_pkg::OP_JBC, cit_pkg::OP_JB, cit_pkg::OP_JNB, cit_pkg::OP_DJNZ_DIR:
        dec = mk(cit_pkg::CLS_COND, cit_pkg::B3, cit_pkg::CLK3); // RQ3
      cit_pkg::OP_JC, cit_pkg::OP_JNC, cit_pkg::OP_JZ, cit_pkg::OP_JNZ:
        dec = mk(cit_pkg::CLS_COND, cit_pkg::B2, cit_pkg::CLK2); // RQ3
      default: begin
      end
    endcase
  end

endmodule
`default_nettype wire

/* File: hw/cit_pkg.sv */
// Operation
// [RQ1] Execution time is counted in single clocks, never in grouped machine cycles.
// [RQ2] Most instructions take as many clocks as they have program bytes.
// [RQ3] A conditional branch not taken finishes one clock sooner than when taken.
// [RQ4] Accumulator operations with a bank register: one byte, one clock.
// [RQ5] Accumulator operations with a direct or immediate byte: two bytes, two clocks.
// [RQ6] Accumulator operations with indirect RAM: one byte, two clocks.
// [RQ7] AND or OR immediate into a direct byte: three bytes, three clocks.
// [RQ8] Logical result written back to a direct byte: two bytes, two clocks.
// [RQ9] Loading the data pointer with a constant: three bytes, three clocks.
// [RQ10] Accumulator rotates and nibble swap: one byte, one clock.
// [RQ11] Moves into indirect RAM take two clocks, including the one-byte form.
// [RQ12] Direct-to-direct move: three bytes, three clocks.
// [RQ13] Code byte read via data pointer: one byte, four to seven clocks.
// [RQ14] Code byte read via program counter: one byte, three clocks.
// [RQ15] External data move via data pointer: one byte, three clocks.
// [RQ16] External data move via 8-bit indirect address: one byte, three clocks.
// [RQ17] Stack push or pop of a direct byte: two bytes, two clocks.
// [RQ18] Exchange of direct byte with accumulator: two bytes, two clocks.
// [RQ19] Low nibble exchange with indirect RAM: one byte, two clocks.
// [RQ20] Some clock counts depend on alignment and flash read timing setting.
// [RQ21] Relative target is following instruction address plus signed 8-bit offset.
// [RQ22] The one unused opcode behaves exactly like no-operation.
package cit_pkg;

  typedef enum logic [4:0] {
    CLS_NOP, CLS_ACC, CLS_ALU_BANK, CLS_ALU_DIR, CLS_ALU_IND, CLS_LOG_DIR_A, CLS_LOG_DIR_IMM,
    CLS_MOV, CLS_MOV_IND_W, CLS_MOV_DIR_DIR, CLS_MOV_DP, CLS_ROT, CLS_CODE_DP,
    CLS_CODE_PC, CLS_XD_DP, CLS_XD_RI, CLS_STACK, CLS_XCH, CLS_XCH_DIR, CLS_NIB_XCH,
    CLS_COND, CLS_OTHER
  } cit_cls_t;

  typedef struct packed {
    cit_cls_t cls;
    logic [1:0] bytes;
    logic [3:0] cycles;
    logic variable;
  } cit_dec_t;

  typedef struct packed {
    logic [7:0] op;
    logic taken;
    logic odd_align;
    logic [1:0] flash_read_timing_setting;
    logic [15:0] next_pc;
    logic [7:0] rel_off;
  } cit_issue_t;

  localparam logic [1:0] B1 = 2'h1, B2 = 2'h2, B3 = 2'h3;
  localparam logic [3:0] CLK1 = 4'h1, CLK2 = 4'h2, CLK3 = 4'h3, CLK4 = 4'h4, CLK8 = 4'h8;
  localparam logic [3:0] CODE_DP_MIN = 4'h4, CODE_DP_MAX = 4'h7;
  localparam logic [3:0] CYC_ONE = 4'h1;

  localparam logic [7:0] OP_NOP = 8'h00, OP_RESV = 8'hA5, OP_INC_DP = 8'hA3, OP_MUL = 8'hA4,
    OP_DIV = 8'h84, OP_DA = 8'hD4, OP_CLR_A = 8'hE4, OP_CPL_A = 8'hF4, OP_RR = 8'h03,
    OP_RRC = 8'h13, OP_RL = 8'h23, OP_RLC = 8'h33, OP_SWAP = 8'hC4, OP_MOV_DIR_DIR = 8'h85,
    OP_MOV_DP = 8'h90, OP_CODE_DP = 8'h93, OP_CODE_PC = 8'h83, OP_XD_RD = 8'hE0,
    OP_XD_WR = 8'hF0, OP_PUSH = 8'hC0, OP_POP = 8'hD0, OP_CLR_C = 8'hC3, OP_CLR_BIT = 8'hC2,
    OP_JBC = 8'h10, OP_JB = 8'h20, OP_JNB = 8'h30, OP_JC = 8'h40, OP_JNC = 8'h50,
    OP_JZ = 8'h60, OP_JNZ = 8'h70, OP_DJNZ_DIR = 8'hD5, OP_XCH_DIR = 8'hC5;

  localparam logic [3:0] ROW_INC = 4'h0, ROW_DEC = 4'h1, ROW_ADD = 4'h2, ROW_ADDC = 4'h3,
    ROW_ORL = 4'h4, ROW_ANL = 4'h5, ROW_XRL = 4'h6, ROW_MOV_IMM = 4'h7, ROW_MOV_TO_DIR = 4'h8,
    ROW_SUBB = 4'h9, ROW_MOV_FROM_DIR = 4'hA, ROW_CJNE = 4'hB, ROW_XCH = 4'hC, ROW_DJNZ = 4'hD,
    ROW_MOV_TO_A = 4'hE, ROW_MOV_FROM_A = 4'hF;

  localparam logic [3:0] COL_A_IMM = 4'h4, COL_DIR = 4'h5, COL_DIR_A = 4'h2, COL_DIR_IMM = 4'h3;
  localparam logic [2:0] COL_IND = 3'h3, COL_XIND = 3'h1;
  localparam logic [3:0] CJNE_FIRST = 4'h4;

endpackage

/* File: tb/cpu_instruction_cycle_timing_test.sv */
`timescale 1ns/100ps
`default_nettype none
module cpu_instruction_cycle_timing_test;
  // Clock, reset and issue side
  logic mclk;
  logic rst_n;
  logic issue_valid;
  cit_pkg::cit_issue_t issue_req;
  // Observed progress
  logic issue_ready;
  logic busy;
  logic retire;
  logic fetch_strobe;
  cit_pkg::cit_cls_t exec_cls;
  logic [1:0] exec_bytes;
  logic [3:0] exec_cycles;
  logic [3:0] cycles_left;
  logic [15:0] branch_target;
  int err_total;
  int comparisons;
  int cyc_count;
  // Whole run is well under a thousand clocks; generous margin
  localparam int CYC_CEIL = 5000;
  // Entry: opcode, byte count, clock count
  logic [15:0] fixed_tbl [0:33];

  cit_core i_dut (.mclk(mclk), .rst_n(rst_n), .issue_valid(issue_valid), .issue_req(issue_req),
    .issue_ready(issue_ready), .busy(busy), .retire(retire), .fetch_strobe(fetch_strobe),
    .exec_cls(exec_cls), .exec_bytes(exec_bytes), .exec_cycles(exec_cycles),
    .cycles_left(cycles_left), .branch_target(branch_target));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expd);
    comparisons++;
    if (seen !== expd) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, expd, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Issue one opcode from idle and follow it clock by clock to retirement
  task automatic run_op(input logic [7:0] op, input logic tk, input logic al, input logic [1:0] frt,
                        input logic [1:0] exp_b, input logic [3:0] exp_c);
    logic [15:0] npc;
    logic [7:0] rel;
    int n;
    int fs;
    npc = {op, ~op};
    rel = op ^ 8'h9C;
    n = 0;
    fs = 0;
    check("ready_idle", {15'h0, issue_ready}, 16'h0001);
    issue_req = '{op: op, taken: tk, odd_align: al, flash_read_timing_setting: frt, next_pc: npc, rel_off: rel};
    issue_valid = 1'b1;
    @(negedge mclk);
    issue_valid = 1'b0;
    while (n < 12) begin
      n++;
      if (fetch_strobe === 1'b1) fs++;
      check("busy", {15'h0, busy}, 16'h0001);
      check("cycles_left", {12'h0, cycles_left}, 16'(exp_c) - 16'(n) + 16'h0001);
      if (retire === 1'b1) break;
      @(negedge mclk);
    end
    check("clock_count", 16'(n), {12'h0, exp_c});
    check("fetch_count", 16'(fs), {14'h0, exp_b});
    check("exec_bytes", {14'h0, exec_bytes}, {14'h0, exp_b});
    check("exec_cycles", {12'h0, exec_cycles}, {12'h0, exp_c});
    check("branch_target", branch_target, npc + {{8{rel[7]}}, rel});
    @(negedge mclk);
    check("busy_after", {15'h0, busy}, 16'h0000);
  endtask

  task automatic t_fixed();
    for (int i = 0; i < 34; i++) begin
      run_op(fixed_tbl[i][15:8], 1'b0, 1'b0, 2'h0, fixed_tbl[i][5:4], fixed_tbl[i][3:0]);
    end
  endtask

  // Taken costs exactly one clock more than not taken, fetch stays at the byte count
  task automatic t_cond();
    logic [7:0] ops [0:7];
    ops = '{8'h10, 8'h20, 8'h30, 8'hD5, 8'h40, 8'h50, 8'h60, 8'h70};
    for (int i = 0; i < 8; i++) begin
      run_op(ops[i], 1'b0, 1'b0, 2'h0, (i < 4) ? 2'h3 : 2'h2, (i < 4) ? 4'h3 : 4'h2);
      run_op(ops[i], 1'b1, 1'b0, 2'h0, (i < 4) ? 2'h3 : 2'h2, (i < 4) ? 4'h4 : 4'h3);
    end
  endtask

  // Code read through the data pointer across every alignment and timing setting
  task automatic t_code_var();
    logic [3:0] extra;
    for (int f = 0; f < 4; f++) begin
      for (int a = 0; a < 2; a++) begin
        extra = (f + a > 3) ? 4'h3 : 4'(f + a);
        run_op(8'h93, 1'b0, 1'(a), 2'(f), 2'h1, 4'h4 + extra);
      end
    end
  endtask

  task automatic t_reserved();
    run_op(8'hA5, 1'b0, 1'b0, 2'h0, 2'h1, 4'h1);
    check("resv_cls", {11'h0, exec_cls}, {11'h0, cit_pkg::CLS_NOP});
    run_op(8'h00, 1'b0, 1'b0, 2'h0, 2'h1, 4'h1);
    check("nop_cls", {11'h0, exec_cls}, {11'h0, cit_pkg::CLS_NOP});
  endtask

  // Second request held while refused, then accepted in the retire clock with no gap
  task automatic t_back_to_back();
    issue_req = '{op: 8'h85, taken: 1'b0, odd_align: 1'b0, flash_read_timing_setting: 2'h0,
                  next_pc: 16'h0100, rel_off: 8'h00};
    issue_valid = 1'b1;
    @(negedge mclk);
    issue_req.op = 8'h28;
    check("b2b_ready1", {15'h0, issue_ready}, 16'h0000);
    @(negedge mclk);
    check("b2b_left2", {12'h0, cycles_left}, 16'h0002);
    @(negedge mclk);
    check("b2b_retire3", {14'h0, retire, issue_ready}, 16'h0003);
    @(negedge mclk);
    issue_valid = 1'b0;
    check("b2b_second", {11'h0, busy, retire, exec_cycles[2:0]}, 16'h0019);
    @(negedge mclk);
    check("b2b_idle", {15'h0, busy}, 16'h0000);
  endtask

  // Reset in mid-instruction clears progress at once
  task automatic t_mid_reset();
    issue_req.op = 8'h93;
    issue_valid = 1'b1;
    @(negedge mclk);
    issue_valid = 1'b0;
    rst_n = 1'b0;
    #5;
    check("rst_state", {10'h0, busy, retire, fetch_strobe, issue_ready, exec_bytes}, 16'h0004);
    check("rst_cls", {11'h0, exec_cls}, {11'h0, cit_pkg::CLS_NOP});
    @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    run_op(8'h28, 1'b0, 1'b0, 2'h0, 2'h1, 4'h1);
  endtask

  always @(posedge mclk) begin
    cyc_count++;
    if (cyc_count == CYC_CEIL) begin
      err_total++;
      end_of_test();
    end
  end

  initial begin
    err_total = 0;
    comparisons = 0;
    cyc_count = 0;
    rst_n = 1'b0;
    issue_valid = 1'b0;
    issue_req = '0;
    fixed_tbl = '{16'h2811, 16'h2F11, 16'h5811, 16'h2522, 16'h2422, 16'h2612, 16'h9612,
                  16'h6422, 16'h5333, 16'h4333, 16'h5222, 16'h4222, 16'h6222, 16'h9033,
                  16'h0311, 16'h1311, 16'h2311, 16'h3311, 16'hC411, 16'hF612, 16'hA622,
                  16'h7622, 16'h8533, 16'h8313, 16'hE013, 16'hF013, 16'hE213, 16'hF213,
                  16'hC022, 16'hD022, 16'hC522, 16'hD612, 16'h0011, 16'hA511};
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    t_fixed();
    t_cond();
    t_code_var();
    t_reserved();
    t_back_to_back();
    t_mid_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
